// ---- design/ovl_pkg.sv ----
// Constants, field layouts and carrier types for the RAM overlay flash emulation block.
// Assumes a 16-bit processor address space and an APB register port with 32-bit data.
package ovl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_SEL_UPPER = 7;
    localparam int BIT_SEL_LOWER = 6;
    localparam logic [7:0] CTRL_RESET = 8'h08;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int BIT_ST_PROTECT = 0;
    localparam int BIT_ST_ACTIVE = 1;
    localparam int BIT_ST_STANDBY = 2;

    // ------------------------------------------------------------
    // Address windows
    // ------------------------------------------------------------
    localparam logic [15:0] RAM_LO = 16'hfc00;
    localparam logic [15:0] RAM_HI = 16'hfd7f;
    localparam logic [15:0] WIN_A_LO = 16'h0080;
    localparam logic [15:0] WIN_A_HI = 16'h00ff;
    localparam logic [15:0] WIN_B_LO = 16'h0080;
    localparam logic [15:0] WIN_B_HI = 16'h017f;
    localparam logic [15:0] WIN_C_LO = 16'h0000;
    localparam logic [15:0] WIN_C_HI = 16'h007f;
    localparam int RAM_OFS_W = 9;

    // ------------------------------------------------------------
    // Overlay selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OVL_NONE = 2'h0,
        OVL_HALF = 2'h1,
        OVL_WIDE = 2'h2,
        OVL_VECT = 2'h3
    } ovl_mode_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
    } ovl_access_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic to_ram;
        logic blocked;
        logic [15:0] addr;
    } ovl_target_s;

endpackage : ovl_pkg

// ---- design/ovl_remap.sv ----
// Combinational address steering for one processor access.
// Assumes the overlay mode and protect level come from the control register of the caller.
module ovl_remap (
    input wire ovl_pkg::ovl_access_s acc,
    input wire ovl_pkg::ovl_mode_e mode,
    input wire logic protect,
    output ovl_pkg::ovl_target_s tgt
);

    logic in_win;
    logic in_ram;
    logic [15:0] ram_phys;

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (mode)
            ovl_pkg::OVL_NONE: in_win = 1'b0;
            ovl_pkg::OVL_HALF: in_win = acc.addr >= ovl_pkg::WIN_A_LO && acc.addr <= ovl_pkg::WIN_A_HI;
            ovl_pkg::OVL_WIDE: in_win = acc.addr >= ovl_pkg::WIN_B_LO && acc.addr <= ovl_pkg::WIN_B_HI;
            ovl_pkg::OVL_VECT: in_win = acc.addr <= ovl_pkg::WIN_C_HI;
        endcase
    end

    // ------------------------------------------------------------
    // Target address
    // ------------------------------------------------------------
    always_comb
    begin
        in_ram = acc.addr >= ovl_pkg::RAM_LO && acc.addr <= ovl_pkg::RAM_HI;
        ram_phys = in_win ? 16'(acc.addr + ovl_pkg::RAM_LO) : acc.addr;
        tgt.valid = acc.valid;
        tgt.write = acc.write;
        tgt.to_ram = in_win || in_ram;
        tgt.addr = (in_win || in_ram) ? 16'(ram_phys - ovl_pkg::RAM_LO) : acc.addr;
        tgt.blocked = acc.valid && acc.write && protect && !(in_win || in_ram);
    end

endmodule : ovl_remap

// ---- design/ovl_top.sv ----
// RAM overlay flash emulation: control register on APB and steering of processor accesses.
// Assumes processor accesses arrive on pclk; the hardware standby pin is asynchronous.
module ovl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire ovl_pkg::ovl_access_s cpu_acc,
    output ovl_pkg::ovl_target_s mem_tgt,
    output logic flash_prog_inhibit,
    output logic [7:0] wait_and_overlay_control
);

    logic [7:0] ctrl_r;
    logic stby_meta_r;
    logic stby_sync_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic inhibit_r;
    ovl_pkg::ovl_target_s tgt_r;
    ovl_pkg::ovl_target_s tgt_nxt;
    ovl_pkg::ovl_mode_e mode;
    logic protect;
    logic apb_access;
    logic ofs_ctrl_hit;
    logic ofs_stat_hit;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Standby pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stby_meta_r <= 1'b0;
            stby_sync_r <= 1'b0;
        end
        else
        begin
            stby_meta_r <= hw_standby;
            stby_sync_r <= stby_meta_r;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apb_access = psel && penable && !pready_r;
    assign ofs_ctrl_hit = paddr[ovl_pkg::ADDR_W-1:0] == ovl_pkg::OFS_CTRL && paddr[31:ovl_pkg::ADDR_W] == '0;
    assign ofs_stat_hit = paddr[ovl_pkg::ADDR_W-1:0] == ovl_pkg::OFS_STAT && paddr[31:ovl_pkg::ADDR_W] == '0;

    always_comb
    begin
        stat_word = '0;
        stat_word[ovl_pkg::BIT_ST_PROTECT] = protect;
        stat_word[ovl_pkg::BIT_ST_ACTIVE] = mode != ovl_pkg::OVL_NONE;
        stat_word[ovl_pkg::BIT_ST_STANDBY] = stby_sync_r;
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Software standby is deliberately not an input to this process.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= ovl_pkg::CTRL_RESET;
        end
        else if (stby_sync_r)
        begin
            ctrl_r <= ovl_pkg::CTRL_RESET;
        end
        else if (apb_access && pwrite && ofs_ctrl_hit)
        begin
            ctrl_r <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end
        else
        begin
            pready_r <= apb_access;
            pslverr_r <= apb_access && !(ofs_ctrl_hit || ofs_stat_hit);
            if (apb_access && !pwrite && ofs_ctrl_hit)
            begin
                prdata_r <= {24'h000000, ctrl_r};
            end
            else if (apb_access && !pwrite && ofs_stat_hit)
            begin
                prdata_r <= stat_word;
            end
            else
            begin
                prdata_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Overlay selection and access steering
    // ------------------------------------------------------------
    assign mode = ovl_pkg::ovl_mode_e'({ctrl_r[ovl_pkg::BIT_SEL_UPPER], ctrl_r[ovl_pkg::BIT_SEL_LOWER]});
    assign protect = ctrl_r[ovl_pkg::BIT_SEL_UPPER] ^ ctrl_r[ovl_pkg::BIT_SEL_LOWER];

    ovl_remap u_remap (
        .acc(cpu_acc),
        .mode(mode),
        .protect(protect),
        .tgt(tgt_nxt)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tgt_r <= '0;
        end
        else
        begin
            tgt_r <= tgt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inhibit_r <= 1'b0;
        end
        else
        begin
            inhibit_r <= protect;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mem_tgt = tgt_r;
    assign flash_prog_inhibit = inhibit_r;
    assign wait_and_overlay_control = ctrl_r;

endmodule : ovl_top

// ---- verif/ovl_cpu_model.sv ----
// Processor model: turns one request per cycle into a registered access.
// Assumes the bench raises go for one cycle per access.
module ovl_cpu_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic wr,
    input wire logic [15:0] adr,
    output ovl_pkg::ovl_access_s acc
);
    // Idle cycles show the inverted last address.
    initial acc = '0;
    always @(posedge pclk)
    begin
        acc.valid <= go;
        acc.write <= go & wr;
        acc.addr <= go ? adr : ~acc.addr;
    end
endmodule : ovl_cpu_model

// ---- verif/ovl_monitor.sv ----
// Checker on the ports of ovl_top.
// Assumes a single clock domain.
module ovl_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hw_standby,
    input wire ovl_pkg::ovl_access_s cpu_acc,
    input wire ovl_pkg::ovl_target_s mem_tgt,
    input wire logic flash_prog_inhibit,
    input wire logic [7:0] wait_and_overlay_control
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] m;
    logic [15:0] a;
    logic v;
    logic hit;
    assign m = wait_and_overlay_control[7:6];
    assign a = cpu_acc.addr;
    assign v = cpu_acc.valid;
    assign hit = (m[1] != m[0] && a >= 16'h0080 && a <= (m[0] ? 16'h00ff : 16'h017f)) || (m == 2'h3 && a <= 16'h007f);
    property p_native;
        v && a >= 16'hfc00 && a <= 16'hfd7f |=> mem_tgt.to_ram && mem_tgt.addr == $past(a) - 16'hfc00;
    endproperty
    a_native: assert property (p_native) else $error("native map");
    property p_none;
        v && m == 2'h0 && a < 16'hfc00 |=> !mem_tgt.to_ram && mem_tgt.addr == $past(a);
    endproperty
    a_none: assert property (p_none) else $error("no remap");
    property p_half;
        v && m == 2'h1 && a < 16'hfc00 |=> mem_tgt.to_ram == $past(hit) && mem_tgt.addr == $past(a);
    endproperty
    a_half: assert property (p_half) else $error("half map");
    property p_wide;
        v && m == 2'h2 && a < 16'hfc00 |=> mem_tgt.to_ram == $past(hit) && mem_tgt.addr == $past(a);
    endproperty
    a_wide: assert property (p_wide) else $error("wide map");
    property p_vect;
        v && m == 2'h3 && a < 16'hfc00 |=> mem_tgt.to_ram == $past(hit) && mem_tgt.addr == $past(a);
    endproperty
    a_vect: assert property (p_vect) else $error("vector map");
    property p_acc;
        v |=> mem_tgt.valid && mem_tgt.write == $past(cpu_acc.write);
    endproperty
    a_acc: assert property (p_acc) else $error("access lost");
    property p_blk;
        v |=> mem_tgt.blocked == $past(cpu_acc.write && m[1] != m[0] && !hit && !(a >= 16'hfc00 && a <= 16'hfd7f));
    endproperty
    a_blk: assert property (p_blk) else $error("protect wrong");
    property p_inh;
        flash_prog_inhibit == $past(^m);
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit wrong");
    property p_rst;
        $rose(presetn) |-> wait_and_overlay_control == 8'h08;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_stby;
        hw_standby [*4] |-> wait_and_overlay_control == 8'h08;
    endproperty
    a_stby: assert property (p_stby) else $error("standby value");
    c_vect: cover property (v && m == 2'h3);
    c_stby: cover property (hw_standby [*4]);
    c_prot: cover property (flash_prog_inhibit && cpu_acc.write);
endmodule : ovl_monitor
bind ovl_top ovl_monitor i_mon (.pclk, .presetn, .hw_standby, .cpu_acc, .mem_tgt, .flash_prog_inhibit,
    .wait_and_overlay_control);

// ---- verif/ovl_top_bench.sv ----
// Bench for ovl_top: APB master, processor model, table of steering cases.
// Assumes APB answers after one wait state and steering lags one cycle.
module ovl_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, sw_standby, go, wr, err;
    logic flash_prog_inhibit;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] adr;
    logic [7:0] ctrl;
    ovl_pkg::ovl_access_s cpu_acc;
    ovl_pkg::ovl_target_s mem_tgt, t;
    int err_total = 0;
    int tests_run = 0;
    logic [34:0] rows [8] = '{{2'h0, 16'h0080, 1'b0, 16'h0080}, {2'h1, 16'h00ff, 1'b1, 16'h00ff},
        {2'h1, 16'h0100, 1'b0, 16'h0100}, {2'h2, 16'h017f, 1'b1, 16'h017f}, {2'h2, 16'h0180, 1'b0, 16'h0180},
        {2'h3, 16'h007f, 1'b1, 16'h007f}, {2'h3, 16'h0080, 1'b0, 16'h0080}, {2'h3, 16'hfd7f, 1'b1, 16'h017f}};
    ovl_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .hw_standby, .sw_standby, .cpu_acc, .mem_tgt, .flash_prog_inhibit, .wait_and_overlay_control(ctrl));
    ovl_cpu_model i_cpu (.pclk, .go, .wr, .adr, .acc(cpu_acc));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task acc(input logic w, input logic [15:0] ad);
        @(posedge pclk);
        go <= 1'b1;
        wr <= w;
        adr <= ad;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        #1 t = mem_tgt;
    endtask : acc
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, hw_standby, sw_standby, go, wr, adr} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk("ctrl", 32'h08, 32'(ctrl));
        foreach (rows[i])
        begin
            apb(1'b1, 32'h0, {24'h0, rows[i][34:33], 6'h08});
            acc(1'b0, rows[i][32:17]);
            chk("to_ram", 32'(rows[i][16]), 32'(t.to_ram));
            chk("addr", 32'(rows[i][15:0]), 32'(t.addr));
        end
        apb(1'b1, 32'h0, 32'h3f);
        acc(1'b0, 16'h0006);
        chk("low bits", 32'h0, 32'(t.to_ram));
        apb(1'b1, 32'h0, 32'hffffff48);
        apb(1'b0, 32'h4, 32'h0);
        chk("status", 32'h3, rd);
        apb(1'b0, 32'h0, 32'h0);
        chk("readback", 32'h48, rd);
        chk("no error", 32'h0, 32'(err));
        chk("inhibit", 32'h1, 32'(flash_prog_inhibit));
        acc(1'b1, 16'h2000);
        chk("blocked", 32'h1, 32'(t.blocked));
        acc(1'b1, 16'h0080);
        chk("overlay write", 32'h0, 32'(t.blocked));
        apb(1'b0, 32'h8, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        apb(1'b1, 32'h0, 32'h0);
        acc(1'b1, 16'h2000);
        chk("released", 32'h0, 32'(t.blocked));
        acc(1'b0, 16'hfc80);
        chk("copy to_ram", 32'h1, 32'(t.to_ram));
        chk("copy source", 32'h80, 32'(t.addr));
        apb(1'b1, 32'h0, 32'hc8);
        sw_standby <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("sw standby", 32'hc8, 32'(ctrl));
        hw_standby <= 1'b1;
        apb(1'b1, 32'h0, 32'hc8);
        chk("hw standby", 32'h08, 32'(ctrl));
        apb(1'b0, 32'h4, 32'h0);
        chk("standby status", 32'h4, rd);
        hw_standby <= 1'b0;
        sw_standby <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b1, 32'h0, 32'hc8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("in reset", 32'h08, 32'(ctrl));
        presetn <= 1'b1;
        apb(1'b0, 32'h0, 32'h0);
        chk("after reset", 32'h08, rd);
        give_verdict;
    end
    initial
    begin
        #10000;
        err_total++;
        give_verdict;
    end
endmodule : ovl_top_bench
